// [dv/ckxp_mem_model.sv]
// Purpose: External memory on the expansion port.
// Assumes: Zero wait states; the device owns all timing.
// Notes:   Read data is a pattern of the address, easy to predict.
`timescale 1ns/1ns
module ckxp_mem_model
  import ckxp_pkg::*;
(
  // Clock.
  input  wire logic              clk,
  // Pins from the device.
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              addr_oe,
  input  wire logic              data_oe,
  // Data back to the device.
  output logic      [DATA_W-1:0] data_in
);
  logic [DATA_W-1:0] junk_ff = 24'hA5_A5A5;
  // An undriven bus flips every cycle so a stale sample cannot pass.
  always @(posedge clk) begin
    junk_ff <= ~junk_ff;
  end
  assign data_in = (addr_oe && !data_oe) ? {6'h15, addr} : junk_ff;
endmodule : ckxp_mem_model

// [dv/ckxp_top_bench.sv]
// Purpose: Self-checking bench for the clock and expansion port block.
// Assumes: Memory model answers at once; strap pin high in reset.
// Notes:   Expected register reset values come from the package constants and the strap.
`timescale 1ns/1ns
module ckxp_top_bench;
  import ckxp_pkg::*;
  logic              clk, rst_n, reg_wr, reg_rd, ext_clk, nmi_pin;
  logic              grant, standby, acc_req, acc_write, ext_run;
  logic              core_clk, nmi_req, acc_done;
  logic              addr_oe, data_oe, attr_oe, ctrl_oe;
  logic [REG_AW-1:0] reg_addr;
  logic [REG_DW-1:0] reg_wdata, reg_rdata, rv;
  logic [ADDR_W-1:0] acc_addr, addr_out;
  logic [DATA_W-1:0] acc_wdata, acc_rdata, data_in, data_out;
  logic [ATTR_N-1:0] acc_attr, attr;
  int                n_fail, check_count, ext_cnt, cnt, er, orr, best;

  ckxp_top u_ckxp_top (
    .CLK(clk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .EXT_CLOCK_IN(ext_clk), .CORE_CLOCK_OUTPUT(core_clk),
    .PLL_INIT_OR_NMI_PIN(nmi_pin), .NMI_REQ(nmi_req), .BUS_GRANT(grant),
    .STANDBY(standby), .ACC_REQ(acc_req), .ACC_WRITE(acc_write),
    .ACC_ADDR(acc_addr), .ACC_WDATA(acc_wdata), .ACC_ATTR(acc_attr),
    .ACC_DONE(acc_done), .ACC_RDATA(acc_rdata), .ADDR_OUT(addr_out),
    .ADDR_OE(addr_oe), .DATA_IN(data_in), .DATA_OUT(data_out),
    .DATA_OE(data_oe), .ATTR_OR_ROW_STROBE(attr), .ATTR_OE(attr_oe),
    .CTRL_OE(ctrl_oe)
  );
  ckxp_mem_model u_ckxp_mem_model (
    .clk(clk), .addr(addr_out), .addr_oe(addr_oe), .data_oe(data_oe),
    .data_in(data_in)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // External clock at a quarter of the core rate while enabled.
  always @(posedge clk) begin
    ext_cnt <= ext_cnt + 1;
    if (ext_run && ext_cnt[0]) ext_clk <= ~ext_clk;
  end

  task automatic cmp(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [3:0] at, input logic [3:0] pol, input int t);
    int n;
    @(posedge clk);
    acc_req <= 1'b1;
    acc_write <= wr;
    acc_addr <= a;
    acc_wdata <= {a[5:0], a};
    acc_attr <= at;
    @(posedge clk);
    acc_req <= 1'b0;
    n = 1;
    #1 cmp("attr_active", 4'(~(at ^ pol)), attr);
    cmp("data_oe", wr, data_oe);
    if (wr) cmp("data_out", {a[5:0], a}, data_out);
    while (acc_done !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    cmp("done_cycles", t + 1, n);
    cmp("attr_idle", 4'(~pol), attr);
    cmp("addr_out", a, addr_out);
    if (!wr) cmp("acc_rdata", {6'h15, a}, acc_rdata);
    repeat (3) @(posedge clk);
    #1 cmp("addr_hold", a, addr_out);
  endtask : access

  // Samples both clocks; reports edge counts and best lag match.
  task automatic clock_run();
    logic [63:0] e, o;
    int bad;
    er = 0;
    orr = 0;
    best = 99;
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      #1 e[i] = ext_clk;
      o[i] = core_clk;
    end
    for (int i = 4; i < 64; i++) begin
      er += int'(e[i] && !e[i-1]);
      orr += int'(o[i] && !o[i-1]);
    end
    for (int l = 1; l < 4; l++) begin
      bad = 0;
      for (int i = 4; i < 64; i++) bad += int'(o[i] !== e[i-l]);
      if (bad < best) best = bad;
    end
  endtask : clock_run

  task automatic summarize();
    if (n_fail == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  initial begin
    #200_000;
    n_fail++;
    summarize();
  end

  initial begin
    {rst_n, reg_wr, reg_rd, ext_run, ext_clk, standby, acc_req} = '0;
    {acc_write, acc_addr, acc_wdata, acc_attr, reg_addr, reg_wdata} = '0;
    {grant, nmi_pin} = 2'b11;
    {n_fail, check_count, ext_cnt} = '0;
    repeat (6) @(posedge clk);
    #1 cmp("oe_reset", 0, {addr_oe, data_oe, attr_oe, ctrl_oe});
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1 cmp("oe_master", 4'hB, {addr_oe, data_oe, attr_oe, ctrl_oe});
    reg_read(REG_PLL_CTRL, rv);
    cmp("pll_ctrl", (32'(PLL_FACT_RST) << PLL_DF_LSB) |
        (32'(PLL_FACT_RST) << PLL_MF_LSB) | 32'h0000_0001, rv);
    reg_read(REG_ATTR_POL, rv);
    cmp("attr_pol", ATTR_POL_RST, rv);
    reg_read(REG_ACC_TIME, rv);
    cmp("acc_time", ACC_TIME_RST, rv);
    reg_read(8'h10, rv);
    cmp("unmapped", 0, rv);
    ext_run <= 1'b1;
    repeat (8) @(posedge clk);
    clock_run();
    cmp("clk_follow", 0, best);
    reg_write(REG_PLL_CTRL, (32'(PLL_FACT_ONE) << PLL_DF_LSB) |
        (32'(PLL_FACT_ONE) << PLL_MF_LSB));
    repeat (8) @(posedge clk);
    clock_run();
    cmp("clk_half", 1, 32'(2 * orr - er <= 1 && 2 * orr - er >= -1));
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      nmi_pin <= 1'(k);
      cnt = 0;
      repeat (12) begin
        @(posedge clk);
        #1 cnt += int'(nmi_req === 1'b1);
      end
      cmp("nmi_pulses", 1 - k, cnt);
    end
    reg_read(REG_STATUS, rv);
    cmp("nmi_seen", 1, rv[ST_NMI_SEEN]);
    for (int k = 0; k < 4; k++) begin
      if (k == 2) reg_write(REG_ATTR_POL, 32'h0000_000A);
      if (k == 3) reg_write(REG_ACC_TIME, 32'h0000_0000);
      access(1'(k), 18'h2_A5C3 ^ (18'(k) << 16), 4'h3 ^ 4'(k),
          (k > 1) ? 4'hA : 4'h0, (k == 3) ? 1 : 2);
    end
    reg_read(REG_ACC_TIME, rv);
    cmp("acc_time_min", ACC_TIME_MIN, rv);
    @(posedge clk);
    standby <= 1'b1;
    repeat (2) @(posedge clk);
    #1 cmp("oe_standby", 0, {addr_oe, data_oe, attr_oe, ctrl_oe});
    @(posedge clk);
    standby <= 1'b0;
    grant <= 1'b0;
    acc_req <= 1'b1;
    repeat (8) begin
      @(posedge clk);
      #1 cmp("refused", 0, {acc_done, addr_oe});
    end
    @(posedge clk);
    acc_req <= 1'b0;
    grant <= 1'b1;
    summarize();
  end
endmodule : ckxp_top_bench

// [dv/ckxp_top_chk.sv]
// Purpose: Port-level assertions for the clock and expansion port block.
// Assumes: One clock domain; every pin enable is high while driving.
// Notes:   Attached by the bind statement after the module.
`timescale 1ns/1ns
module ckxp_top_chk
  import ckxp_pkg::*;
(
  // Clock and reset.
  input wire logic              CLK,
  input wire logic              RST_N,
  // Watched ports.
  input wire logic              REG_RD,
  input wire logic [REG_DW-1:0] REG_RDATA,
  input wire logic              BUS_GRANT,
  input wire logic              STANDBY,
  input wire logic              ACC_REQ,
  input wire logic              ACC_DONE,
  input wire logic              NMI_REQ,
  input wire logic [ADDR_W-1:0] ADDR_OUT,
  input wire logic              ADDR_OE,
  input wire logic              DATA_OE,
  input wire logic              ATTR_OE,
  input wire logic              CTRL_OE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic any_oe;
  assign any_oe = ADDR_OE | DATA_OE | ATTR_OE | CTRL_OE;
  chk_reset_float:
    assert property (disable iff (1'b0) !RST_N |-> !any_oe)
    else $error("port driven during reset");
  chk_standby_float:
    assert property (STANDBY |=> !any_oe)
    else $error("port driven in standby");
  chk_grant_float:
    assert property (!BUS_GRANT |=> !any_oe)
    else $error("port driven without grant");
  chk_oe_group:
    assert property (ADDR_OE == ATTR_OE && ATTR_OE == CTRL_OE)
    else $error("pin enables disagree");
  chk_data_owner:
    assert property (DATA_OE |-> ADDR_OE)
    else $error("data driven while not master");
  chk_addr_hold:
    assert property ($changed(ADDR_OUT) |-> $past(ACC_REQ) || $past(ACC_REQ, 2))
    else $error("address moved without access");
  chk_done_pulse:
    assert property (ACC_DONE |=> !ACC_DONE [*2])
    else $error("access done too long");
  chk_nmi_pulse:
    assert property (NMI_REQ |=> !NMI_REQ)
    else $error("interrupt request too long");
  chk_rdata_idle:
    assert property (!$past(REG_RD) |-> REG_RDATA == '0)
    else $error("read data outside its cycle");
  cov_done: cover property (ACC_DONE);
  cov_nmi: cover property (NMI_REQ);
  cov_standby: cover property (STANDBY ##1 !ADDR_OE);
endmodule : ckxp_top_chk

bind ckxp_top ckxp_top_chk u_ckxp_top_chk (
  .CLK(CLK), .RST_N(RST_N), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .BUS_GRANT(BUS_GRANT), .STANDBY(STANDBY), .ACC_REQ(ACC_REQ),
  .ACC_DONE(ACC_DONE), .NMI_REQ(NMI_REQ), .ADDR_OUT(ADDR_OUT),
  .ADDR_OE(ADDR_OE), .DATA_OE(DATA_OE), .ATTR_OE(ATTR_OE),
  .CTRL_OE(CTRL_OE)
);

// [include/ckxp_pkg.sv]
// Purpose: Shared constants for the clock output and expansion port block.
// Assumes: Registers sit one per 32-bit word on the plain register port.
// Notes:   Field positions and reset values live here and nowhere else.
package ckxp_pkg;

  // Register port geometry.
  localparam int          REG_AW        = 8;
  localparam int          REG_DW        = 32;
  localparam logic [7:0]  REG_PLL_CTRL  = 8'h00;
  localparam logic [7:0]  REG_ATTR_POL  = 8'h04;
  localparam logic [7:0]  REG_STATUS    = 8'h08;
  localparam logic [7:0]  REG_ACC_TIME  = 8'h0C;

  // PLL control fields.
  localparam int          PLL_EN_BIT    = 0;
  localparam int          PLL_MF_LSB    = 1;
  localparam int          PLL_DF_LSB    = 5;
  localparam int          PLL_FW        = 4;
  localparam logic [3:0]  PLL_FACT_ONE  = 4'h1;
  localparam logic [3:0]  PLL_FACT_RST  = 4'h1;

  // Status fields.
  localparam int          ST_PLL_EN     = 0;
  localparam int          ST_MASTER     = 1;
  localparam int          ST_STANDBY    = 2;
  localparam int          ST_BUSY       = 3;
  localparam int          ST_NMI_SEEN   = 4;
  localparam int          ST_CORE_CLOCK_OUTPUT     = 5;

  // Expansion port widths.
  localparam int          ADDR_W        = 18;
  localparam int          DATA_W        = 24;
  localparam int          ATTR_N        = 4;

  // Reset values and the access time minimum.
  localparam logic [3:0]  ATTR_POL_RST  = 4'h0;
  localparam logic [3:0]  ACC_TIME_RST  = 4'h2;
  localparam logic [3:0]  ACC_TIME_MIN  = 4'h1;
  localparam logic [17:0] ADDR_RST      = 18'h0_0000;
  localparam logic [23:0] DATA_RST      = 24'h00_0000;

  typedef enum logic [1:0] {
    CKXP_IDLE,
    CKXP_ACT,
    CKXP_DONE
  } ckxp_state_t;

endpackage : ckxp_pkg

// [src/ckxp_clkgen.sv]
// Purpose: Builds the core clock phase that the top registers into the clock output.
// Assumes: The external clock input is sampled as a synchronous level.
// Notes:   The output is the core phase itself; the clock output pin in the top lags it by one flop.
`timescale 1ns/1ns
module ckxp_clkgen
  import ckxp_pkg::*;
(
  // Clock and reset.
  input  wire logic            clk,
  input  wire logic            rst_n,
  // Configuration.
  input  wire logic            ext_clock_in,
  input  wire logic            pll_enable_bit,
  input  wire logic [PLL_FW-1:0] mult_fact,
  input  wire logic [PLL_FW-1:0] div_fact,
  // Core phase.
  output logic                 core_phase
);

  logic              ext_prev_ff;
  logic              phase_ff;
  logic [PLL_FW-1:0] cnt_ff;
  logic              unity;
  logic              ext_rise;

  assign unity    = (mult_fact == PLL_FACT_ONE) && (div_fact == PLL_FACT_ONE);
  assign ext_rise = ext_clock_in && !ext_prev_ff;
  assign core_phase = phase_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_prev_ff <= 1'b0;
    end else begin
      ext_prev_ff <= ext_clock_in;
    end
  end

  // A zero divide factor is treated as one so the counter never stalls.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff <= 1'b0;
      cnt_ff   <= '0;
    end else if (!pll_enable_bit) begin
      cnt_ff <= '0;
      if (ext_rise) begin
        phase_ff <= !phase_ff;
      end
    end else if (unity) begin
      cnt_ff   <= '0;
      phase_ff <= ext_clock_in;
    end else if (cnt_ff + PLL_FACT_ONE >= div_fact) begin
      cnt_ff   <= '0;
      phase_ff <= !phase_ff;
    end else begin
      cnt_ff <= cnt_ff + PLL_FACT_ONE;
    end
  end

endmodule : ckxp_clkgen

// [src/ckxp_nmi_sync.sv]
// Purpose: Synchronises the init/interrupt pin and finds falling edges.
// Assumes: The pin may change at any time relative to the clock.
// Notes:   Edges are only reported while armed, i.e. after reset release.
`timescale 1ns/1ns
module ckxp_nmi_sync
  import ckxp_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Pin side.
  input  wire logic pin,
  input  wire logic arm,
  // Event.
  output logic      fall_pulse
);

  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // No reset here: the stages track the pin through reset, so a pin
  // strapped low and left low gives no false edge once armed.
  always_ff @(posedge clk) begin
    meta_ff <= pin;
    sync_ff <= meta_ff;
    prev_ff <= sync_ff;
  end

  assign fall_pulse = arm && rst_n && prev_ff && !sync_ff;

endmodule : ckxp_nmi_sync

// [src/ckxp_top.sv]
// Purpose: Clock output, PLL init/interrupt pin and expansion port pins.
// Assumes: Core access requests and grant inputs are synchronous to CLK.
// Notes:   Pin enables are high while the block drives the pin.
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ns
module ckxp_top
  import ckxp_pkg::*;
(
  // Clock and reset.
  input  wire logic              CLK,
  input  wire logic              RST_N,
  // Register port.
  input  wire logic [REG_AW-1:0] REG_ADDR,
  input  wire logic [REG_DW-1:0] REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic      [REG_DW-1:0] REG_RDATA,
  // Clock pins.
  input  wire logic              EXT_CLOCK_IN,
  output logic                   CORE_CLOCK_OUTPUT,
  // Init / interrupt pin.
  input  wire logic              PLL_INIT_OR_NMI_PIN,
  output logic                   NMI_REQ,
  // Bus ownership.
  input  wire logic              BUS_GRANT,
  input  wire logic              STANDBY,
  // Core access request.
  input  wire logic              ACC_REQ,
  input  wire logic              ACC_WRITE,
  input  wire logic [ADDR_W-1:0] ACC_ADDR,
  input  wire logic [DATA_W-1:0] ACC_WDATA,
  input  wire logic [ATTR_N-1:0] ACC_ATTR,
  output logic                   ACC_DONE,
  output logic      [DATA_W-1:0] ACC_RDATA,
  // Address bus pins.
  output logic      [ADDR_W-1:0] ADDR_OUT,
  output logic                   ADDR_OE,
  // Data bus pins.
  input  wire logic [DATA_W-1:0] DATA_IN,
  output logic      [DATA_W-1:0] DATA_OUT,
  output logic                   DATA_OE,
  // Attribute / row strobe pins.
  output logic      [ATTR_N-1:0] ATTR_OR_ROW_STROBE,
  output logic                   ATTR_OE,
  // Read, write, bus busy, column strobe and bus clock enable group.
  output logic                   CTRL_OE
);

  // Reset synchroniser.
  logic              rst_meta_ff;
  logic              rst_n_ff;
  // Registers.
  logic              pll_enable_bit_ff;
  logic [PLL_FW-1:0] mult_ff;
  logic [PLL_FW-1:0] div_ff;
  logic [ATTR_N-1:0] attr_pol_ff;
  logic [PLL_FW-1:0] acc_time_ff;
  logic              nmi_seen_ff;
  logic [REG_DW-1:0] rdata_ff;
  logic [REG_DW-1:0] nxt_rdata;
  // Clock output and interrupt.
  logic              core_phase;
  logic              core_clock_output_ff;
  logic              nmi_fall;
  logic              nmi_ff;
  // Expansion port.
  ckxp_state_t       state_ff;
  ckxp_state_t       nxt_state;
  logic [PLL_FW-1:0] wait_ff;
  logic              owner;
  logic              start;
  logic              wr_ff;
  logic [ATTR_N-1:0] sel_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] dout_ff;
  logic [DATA_W-1:0] rdata_acc_ff;
  logic              done_ff;
  logic              addr_oe_ff;
  logic              data_oe_ff;
  logic              ctrl_oe_ff;
  logic [ATTR_N-1:0] attr_ff;

  // Reset release through two flops; assertion stays asynchronous.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // The enable bit has no reset constant: it is strapped from the pin on
  // every edge while reset is held, so the last level before release wins.
  always_ff @(posedge CLK) begin
    if (!rst_n_ff) begin
      pll_enable_bit_ff <= PLL_INIT_OR_NMI_PIN;
    end else if (REG_WR && REG_ADDR == REG_PLL_CTRL) begin
      pll_enable_bit_ff <= REG_WDATA[PLL_EN_BIT];
    end
  end

  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      mult_ff <= PLL_FACT_RST;
      div_ff  <= PLL_FACT_RST;
    end else if (REG_WR && REG_ADDR == REG_PLL_CTRL) begin
      mult_ff <= REG_WDATA[PLL_MF_LSB +: PLL_FW];
      div_ff  <= REG_WDATA[PLL_DF_LSB +: PLL_FW];
    end
  end

  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      attr_pol_ff <= ATTR_POL_RST;
    end else if (REG_WR && REG_ADDR == REG_ATTR_POL) begin
      attr_pol_ff <= REG_WDATA[ATTR_N-1:0];
    end
  end

  // Access length below one cycle would make a strobe vanish, so clamp it.
  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      acc_time_ff <= ACC_TIME_RST;
    end else if (REG_WR && REG_ADDR == REG_ACC_TIME) begin
      acc_time_ff <= (REG_WDATA[PLL_FW-1:0] < ACC_TIME_MIN) ?
                     ACC_TIME_MIN : REG_WDATA[PLL_FW-1:0];
    end
  end

  // Sticky interrupt record; a new edge wins over a write-one clear.
  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      nmi_seen_ff <= 1'b0;
    end else if (nmi_fall) begin
      nmi_seen_ff <= 1'b1;
    end else if (REG_WR && REG_ADDR == REG_STATUS &&
                 REG_WDATA[ST_NMI_SEEN]) begin
      nmi_seen_ff <= 1'b0;
    end
  end

  always_comb begin
    nxt_rdata = '0;
    case (REG_ADDR)
      REG_PLL_CTRL: begin
        nxt_rdata[PLL_EN_BIT]           = pll_enable_bit_ff;
        nxt_rdata[PLL_MF_LSB +: PLL_FW] = mult_ff;
        nxt_rdata[PLL_DF_LSB +: PLL_FW] = div_ff;
      end
      REG_ATTR_POL: begin
        nxt_rdata[ATTR_N-1:0] = attr_pol_ff;
      end
      REG_STATUS: begin
        nxt_rdata[ST_PLL_EN]   = pll_enable_bit_ff;
        nxt_rdata[ST_MASTER]   = owner;
        nxt_rdata[ST_STANDBY]  = STANDBY;
        nxt_rdata[ST_BUSY]     = (state_ff != CKXP_IDLE);
        nxt_rdata[ST_NMI_SEEN] = nmi_seen_ff;
        nxt_rdata[ST_CORE_CLOCK_OUTPUT]   = core_clock_output_ff;
      end
      REG_ACC_TIME: begin
        nxt_rdata[PLL_FW-1:0] = acc_time_ff;
      end
      default: begin
        nxt_rdata = '0;
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= REG_RD ? nxt_rdata : '0;
    end
  end

  ckxp_clkgen u_clkgen (
    .clk            (CLK),
    .rst_n          (rst_n_ff),
    .ext_clock_in   (EXT_CLOCK_IN),
    .pll_enable_bit (pll_enable_bit_ff),
    .mult_fact      (mult_ff),
    .div_fact       (div_ff),
    .core_phase     (core_phase)
  );

  // One flop from the core phase keeps a fixed alignment to it.
  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      core_clock_output_ff <= 1'b0;
    end else begin
      core_clock_output_ff <= core_phase;
    end
  end

  ckxp_nmi_sync u_nmi (
    .clk        (CLK),
    .rst_n      (rst_n_ff),
    .pin        (PLL_INIT_OR_NMI_PIN),
    .arm        (rst_n_ff),
    .fall_pulse (nmi_fall)
  );

  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      nmi_ff <= 1'b0;
    end else begin
      nmi_ff <= nmi_fall;
    end
  end

  // Ownership is lost at once in standby, whatever the arbiter says.
  assign owner = BUS_GRANT && !STANDBY;
  assign start = owner && ACC_REQ && (state_ff == CKXP_IDLE);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CKXP_IDLE: begin
        if (start) begin
          nxt_state = CKXP_ACT;
        end
      end
      CKXP_ACT: begin
        if (!owner) begin
          nxt_state = CKXP_IDLE;
        end else if (wait_ff <= ACC_TIME_MIN) begin
          nxt_state = CKXP_DONE;
        end
      end
      CKXP_DONE: begin
        nxt_state = CKXP_IDLE;
      end
      default: begin
        nxt_state = CKXP_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= CKXP_IDLE;
      wait_ff  <= '0;
    end else begin
      state_ff <= nxt_state;
      if (start) begin
        wait_ff <= acc_time_ff;
      end else if (state_ff == CKXP_ACT) begin
        wait_ff <= wait_ff - ACC_TIME_MIN;
      end
    end
  end

  // Address and write data load only when an access starts, so the pins
  // do not toggle while no external space is touched.
  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      addr_ff <= ADDR_RST;
      dout_ff <= DATA_RST;
      wr_ff   <= 1'b0;
      sel_ff  <= '0;
    end else if (start) begin
      addr_ff <= ACC_ADDR;
      dout_ff <= ACC_WDATA;
      wr_ff   <= ACC_WRITE;
      sel_ff  <= ACC_ATTR;
    end
  end

  // Read data captured on the last cycle of a read access.
  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rdata_acc_ff <= DATA_RST;
      done_ff      <= 1'b0;
    end else begin
      done_ff <= (nxt_state == CKXP_DONE);
      if (nxt_state == CKXP_DONE && !wr_ff) begin
        rdata_acc_ff <= DATA_IN;
      end
    end
  end

  // Address and control enables follow ownership, the data enable only in a write access; reset clears them, so all float in reset.
  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      addr_oe_ff <= 1'b0;
      ctrl_oe_ff <= 1'b0;
      data_oe_ff <= 1'b0;
    end else begin
      addr_oe_ff <= owner;
      ctrl_oe_ff <= owner;
      data_oe_ff <= owner && (start ? ACC_WRITE : wr_ff) &&
                    (nxt_state != CKXP_IDLE);
    end
  end

  // Attribute lines are active inside an access and in reset, which loads ATTR_POL_RST; the polarity bit
  // picks the active level, and between accesses after reset they sit inactive.
  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      attr_ff <= ATTR_POL_RST;
    end else if (nxt_state == CKXP_ACT) begin
      attr_ff <= ~((start ? ACC_ATTR : sel_ff) ^ attr_pol_ff);
    end else begin
      attr_ff <= ~attr_pol_ff;
    end
  end

  assign REG_RDATA          = rdata_ff;
  assign CORE_CLOCK_OUTPUT  = core_clock_output_ff;
  assign NMI_REQ            = nmi_ff;
  assign ACC_DONE           = done_ff;
  assign ACC_RDATA          = rdata_acc_ff;
  assign ADDR_OUT           = addr_ff;
  assign ADDR_OE            = addr_oe_ff;
  assign DATA_OUT           = dout_ff;
  assign DATA_OE            = data_oe_ff;
  assign ATTR_OR_ROW_STROBE = attr_ff;
  assign ATTR_OE            = ctrl_oe_ff;
  assign CTRL_OE            = ctrl_oe_ff;

endmodule : ckxp_top
